// ---- design/acsr_defines.svh ----
`ifndef ACSR_DEFINES_SVH
`define ACSR_DEFINES_SVH

// clock period of the block
`define ACSR_CLK_NS       10
// result width and readout frame length
`define ACSR_RES_BITS     12
`define ACSR_FRAME_BITS   16
`define ACSR_LEAD_ZEROS   4'h0
// longest conversion time in high-rate mode, rounded down to cycles
`define ACSR_CONV_NS      8000
`define ACSR_CONV_CYC     (`ACSR_CONV_NS / `ACSR_CLK_NS)
// one successive-approximation trial, twelve of them fit the conversion
`define ACSR_BIT_CYC      (`ACSR_CONV_CYC / `ACSR_RES_BITS)
// wake-up budget after power-down (14 us total less 8 us conversion)
`define ACSR_WAKE_NS      6000
`define ACSR_WAKE_CYC     (`ACSR_WAKE_NS / `ACSR_CLK_NS)
// least data hold after the last serial clock fall, rounded up
`define ACSR_HOLD_NS      10
`define ACSR_HOLD_CYC     ((`ACSR_HOLD_NS + `ACSR_CLK_NS - 1) / `ACSR_CLK_NS)
// longest bus relinquish time, rounded down
`define ACSR_RELQ_NS      50
`define ACSR_RELQ_CYC     (`ACSR_RELQ_NS / `ACSR_CLK_NS)
// result buffer depth
`define ACSR_FIFO_DEPTH   8

`endif

// ---- design/acsr_pkg.sv ----
package acsr_pkg;

  // conversion control states
  typedef enum logic [2:0] {
    ACSR_ST_IDLE  = 3'b000,
    ACSR_ST_CONV  = 3'b001,
    ACSR_ST_STORE = 3'b010,
    ACSR_ST_SLEEP = 3'b011,
    ACSR_ST_WAKE  = 3'b100
  } acsr_state_t;

  // conversion code and readout frame
  typedef logic [11:0] acsr_code_t;
  typedef logic [15:0] acsr_frame_t;

endpackage : acsr_pkg

// ---- design/acsr_sync.sv ----
`timescale 1ns/1ps

// two-stage synchroniser for pin inputs
module acsr_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         i_clock,
  input  wire logic         i_rst_b,
  // asynchronous in, synchronised out
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      meta_r <= '0;
      o_sync <= '0;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

endmodule : acsr_sync

// ---- design/acsr_fifo.sv ----
`timescale 1ns/1ps

// result buffer with valid/ready on both sides
module acsr_fifo #(
  parameter int W = 12,
  parameter int D = 8
) (
  // clock and reset
  input  wire logic         i_clock,
  input  wire logic         i_rst_b,
  // fill side
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  // drain side
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic      [W-1:0] o_out_data
);

  localparam int AW = $clog2(D);

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0]   count_r;

  // handshake decode
  wire push = i_in_valid & o_in_ready;
  wire pop  = o_out_valid & i_out_ready;

  assign o_in_ready  = (count_r != (AW+1)'(D));
  assign o_out_valid = (count_r != '0);
  assign o_out_data  = mem[rd_ptr_r];

  // storage
  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wr_ptr_r] <= i_in_data;
    end
  end

  // pointers wrap at depth
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(D - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(D - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : acsr_fifo

// ---- design/acsr_top.sv ----
`timescale 1ns/1ps
`include "acsr_defines.svh"

// Contract
// - convert-start fall holds sample, starts conversion
// - conversion ends with start low: power down
// - powered down, start rise begins wake-up
// - busy high from start fall to completion
// - each serial clock fall presents next bit
// - frame is four zeros then twelve bits
// - after sixteenth fall hold briefly, then release
// - result is straight unsigned binary code
// - conversion within 8 us, 14 us with wake
module acsr_top (
  // clock and reset
  input  wire logic               i_clock,
  input  wire logic               i_rst_b,
  // conversion control pins
  input  wire logic               i_convert_start_n,
  output logic                    o_busy,
  output logic                    o_track_hold,
  output logic                    o_power_down,
  // successive-approximation loop
  input  wire logic               i_comparator_above,
  output acsr_pkg::acsr_code_t    o_dac_code,
  // serial readout pins
  input  wire logic               i_serial_clock,
  output logic                    o_readout_serial_out,
  output logic                    o_readout_serial_oe_n
);
  import acsr_pkg::*;

  localparam logic [9:0] BIT_LAST  = 10'(`ACSR_BIT_CYC - 1);
  localparam logic [9:0] WAKE_LAST = 10'(`ACSR_WAKE_CYC - 1);
  localparam logic [3:0] HOLD_LAST = 4'(`ACSR_HOLD_CYC - 1);
  localparam logic [4:0] LAST_EDGE = 5'(`ACSR_FRAME_BITS - 1);
  localparam int         CONV_MAX  = `ACSR_CONV_CYC;
  localparam int         RELQ_MAX  = `ACSR_RELQ_CYC;

  // synchronised pins and edge detection
  logic [2:0] pin_sync;
  logic       start_n_d_r;
  logic       sclk_d_r;

  acsr_sync #(
    .W (3)
  ) u_sync (
    .i_clock (i_clock),
    .i_rst_b (i_rst_b),
    .i_async ({i_convert_start_n, i_serial_clock, i_comparator_above}),
    .o_sync  (pin_sync)
  );

  wire start_n    = pin_sync[2];
  wire sclk       = pin_sync[1];
  wire cmp_above  = pin_sync[0];
  wire start_fall = start_n_d_r & ~start_n;
  wire start_rise = ~start_n_d_r & start_n;
  wire sclk_fall  = sclk_d_r & ~sclk;

  // delayed copies for edge detection
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      start_n_d_r <= 1'b0;
      sclk_d_r    <= 1'b0;
    end else begin
      start_n_d_r <= start_n;
      sclk_d_r    <= sclk;
    end
  end

  // conversion control state
  acsr_state_t state_r;
  acsr_state_t state_nxt;
  logic [9:0]  cnt_r;
  logic [9:0]  cnt_nxt;
  logic [3:0]  idx_r;
  logic [3:0]  idx_nxt;
  acsr_code_t  code_r;
  acsr_code_t  code_nxt;
  logic        pend_r;
  logic        pend_nxt;

  // result buffer handshake
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic        fifo_out_ready;
  acsr_code_t  fifo_out_data;

  wire step_end = (cnt_r == BIT_LAST);
  wire store_go = (state_r == ACSR_ST_STORE) & fifo_in_ready;

  // trial bit for the current index, msb first
  wire acsr_code_t trial_bit = acsr_code_t'(12'h001 << idx_r);

  // next-state logic for conversion, sleep and wake-up
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    idx_nxt   = idx_r;
    code_nxt  = code_r;
    pend_nxt  = pend_r;
    case (state_r)
      ACSR_ST_IDLE: begin
        if (start_fall) begin
          state_nxt = ACSR_ST_CONV;
          cnt_nxt   = '0;
          idx_nxt   = 4'(`ACSR_RES_BITS - 1);
          code_nxt  = 12'h800;
        end
      end
      ACSR_ST_CONV: begin
        cnt_nxt = cnt_r + 10'h001;
        if (step_end) begin
          cnt_nxt = '0;
          // keep the trial bit only when input is above dac level
          if (!cmp_above) begin
            code_nxt = code_r & ~trial_bit;
          end
          if (idx_r == 4'h0) begin
            state_nxt = ACSR_ST_STORE;
          end else begin
            idx_nxt  = idx_r - 4'h1;
            code_nxt = code_nxt | (trial_bit >> 1);
          end
        end
      end
      ACSR_ST_STORE: begin
        // stall here while the result buffer is full
        if (fifo_in_ready) begin
          state_nxt = start_n ? ACSR_ST_IDLE : ACSR_ST_SLEEP;
        end
      end
      ACSR_ST_SLEEP: begin
        if (start_rise) begin
          state_nxt = ACSR_ST_WAKE;
          cnt_nxt   = '0;
        end
      end
      ACSR_ST_WAKE: begin
        cnt_nxt = cnt_r + 10'h001;
        if (start_fall) begin
          pend_nxt = 1'b1; // sample held, conversion waits for wake-up
        end
        if (cnt_r == WAKE_LAST) begin
          cnt_nxt = '0;
          if (pend_r | start_fall) begin
            state_nxt = ACSR_ST_CONV;
            idx_nxt   = 4'(`ACSR_RES_BITS - 1);
            code_nxt  = 12'h800;
            pend_nxt  = 1'b0;
          end else begin
            state_nxt = ACSR_ST_IDLE;
          end
        end
      end
      default: begin
        state_nxt = ACSR_ST_IDLE;
        pend_nxt  = 1'b0;
      end
    endcase
  end

  // control registers
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      state_r <= ACSR_ST_IDLE;
      cnt_r   <= '0;
      idx_r   <= '0;
      code_r  <= '0;
      pend_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      idx_r   <= idx_nxt;
      code_r  <= code_nxt;
      pend_r  <= pend_nxt;
    end
  end

  // status outputs
  wire converting = (state_r == ACSR_ST_CONV) | (state_r == ACSR_ST_STORE);
  assign o_busy       = converting | pend_r;
  assign o_track_hold = converting | pend_r;
  assign o_power_down = (state_r == ACSR_ST_SLEEP);
  assign o_dac_code   = code_r;

  // finished results wait here for the host to read them
  acsr_fifo #(
    .W (`ACSR_RES_BITS),
    .D (`ACSR_FIFO_DEPTH)
  ) u_fifo (
    .i_clock     (i_clock),
    .i_rst_b     (i_rst_b),
    .i_in_valid  (state_r == ACSR_ST_STORE),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (code_r),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (fifo_out_ready),
    .o_out_data  (fifo_out_data)
  );

  // serial readout state
  acsr_frame_t frame_r;
  logic [4:0]  edge_cnt_r;
  logic [3:0]  hold_cnt_r;
  logic        drive_r;
  logic        final_r;
  logic        sout_r;

  // a new frame is taken only while the line is released
  assign fifo_out_ready = ~drive_r;
  wire   frame_load     = fifo_out_valid & fifo_out_ready;
  wire   shift_edge     = drive_r & ~final_r & sclk_fall;
  wire   last_edge      = shift_edge & (edge_cnt_r == LAST_EDGE);
  wire   release_now    = final_r & (hold_cnt_r == HOLD_LAST);

  // frame load, bit shifting and line release
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      frame_r    <= '0;
      edge_cnt_r <= '0;
      hold_cnt_r <= '0;
      drive_r    <= 1'b0;
      final_r    <= 1'b0;
      sout_r     <= 1'b0;
    end else if (frame_load) begin
      frame_r    <= {`ACSR_LEAD_ZEROS, fifo_out_data};
      edge_cnt_r <= '0;
      hold_cnt_r <= '0;
      drive_r    <= 1'b1;
      final_r    <= 1'b0;
      sout_r     <= 1'b0; // first leading zero
    end else if (last_edge) begin
      final_r    <= 1'b1;
    end else if (shift_edge) begin
      frame_r    <= {frame_r[14:0], 1'b0};
      sout_r     <= frame_r[14];
      edge_cnt_r <= edge_cnt_r + 5'h01;
    end else if (release_now) begin
      drive_r    <= 1'b0;
      final_r    <= 1'b0;
      sout_r     <= 1'b0;
    end else if (final_r) begin
      hold_cnt_r <= hold_cnt_r + 4'h1;
    end
  end

  assign o_readout_serial_out  = sout_r;
  assign o_readout_serial_oe_n = ~drive_r;

  // checks on conversion control
  property p_start_holds;
    @(posedge i_clock) disable iff (!i_rst_b)
      (state_r == ACSR_ST_IDLE) && start_fall |=> o_track_hold && o_busy && (code_r == 12'h800);
  endproperty
  a_start_holds: assert property (p_start_holds)
    else $error("start fall did not begin a conversion");

  property p_sleep_entry;
    @(posedge i_clock) disable iff (!i_rst_b)
      store_go && !start_n |=> o_power_down && !o_busy;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("no power-down after conversion with start low");

  property p_wake_start;
    @(posedge i_clock) disable iff (!i_rst_b)
      o_power_down && start_rise |=> !o_power_down ##0 (state_r == ACSR_ST_WAKE);
  endproperty
  a_wake_start: assert property (p_wake_start)
    else $error("start rise did not begin wake-up");

  property p_busy_drop;
    @(posedge i_clock) disable iff (!i_rst_b)
      $fell(o_busy) |-> $past(store_go);
  endproperty
  a_busy_drop: assert property (p_busy_drop)
    else $error("busy fell before the result was stored");

  property p_conv_time;
    @(posedge i_clock) disable iff (!i_rst_b)
      $rose(state_r == ACSR_ST_CONV) |-> ##[1:CONV_MAX] (state_r == ACSR_ST_STORE);
  endproperty
  a_conv_time: assert property (p_conv_time)
    else $error("conversion ran past its time limit");

  property p_keep_bit;
    @(posedge i_clock) disable iff (!i_rst_b)
      (state_r == ACSR_ST_CONV) && step_end && cmp_above |=> code_r[$past(idx_r)];
  endproperty
  a_keep_bit: assert property (p_keep_bit)
    else $error("trial bit dropped although input was above");

  // checks on serial readout
  property p_shift_bit;
    @(posedge i_clock) disable iff (!i_rst_b)
      shift_edge && !last_edge |=> (sout_r == $past(frame_r[14])) && !o_readout_serial_oe_n;
  endproperty
  a_shift_bit: assert property (p_shift_bit)
    else $error("serial clock fall did not present the next bit");

  property p_lead_zeros;
    @(posedge i_clock) disable iff (!i_rst_b)
      frame_load |=> (frame_r[15:12] == 4'h0) && (frame_r[11:0] == $past(fifo_out_data));
  endproperty
  a_lead_zeros: assert property (p_lead_zeros)
    else $error("frame did not open with four zeros and the result");

  property p_release;
    @(posedge i_clock) disable iff (!i_rst_b)
      last_edge |=> (o_readout_serial_out == $past(sout_r)) && !o_readout_serial_oe_n
        ##[1:RELQ_MAX] o_readout_serial_oe_n;
  endproperty
  a_release: assert property (p_release)
    else $error("line not held then released after the last bit");

endmodule : acsr_top

// ---- bench/acsr_host.sv ----
`timescale 1ns/1ps

// host side: clocks one readout frame out per go request
module acsr_host (
  // request and data line
  input  wire logic            i_go,
  input  wire logic            i_readout_serial_out,
  // serial clock and captured frame
  output logic                 o_sclk,
  output acsr_pkg::acsr_frame_t o_word,
  output logic                 o_done
);
  import acsr_pkg::*;

  // serial clock rests low outside frames, 125 ns period, 62.5 ns each half
  initial begin : frame
    acsr_frame_t w;
    o_sclk = 1'b0;
    o_done = 1'b0;
    o_word = '0;
    forever begin
      @(posedge i_go);
      w = '0;
      for (int k = 0; k < 16; k++) begin
        #62.5 o_sclk = 1'b1;
        #62.5 o_sclk = 1'b0;
        w = {w[14:0], i_readout_serial_out}; // old bit taken at the launching fall
      end
      o_word = w;
      o_done = 1'b1;
      #20 o_done = 1'b0;
    end
  end
endmodule : acsr_host

// ---- bench/acsr_top_tb.sv ----
`timescale 1ns/1ps

`define CHK(nm, ex, gt) begin tests_run++; if ((ex) !== (gt)) begin fails++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, gt); end end

module acsr_top_tb;
  import acsr_pkg::*;

  // stimulus and observed signals
  logic        clk, rst_b, cs_n, go, flip;
  logic        busy, th, pd, sclk, sdo, oe_n, done;
  acsr_code_t  dac, vin;
  acsr_frame_t word;
  acsr_frame_t expq[$];
  int          fails, tests_run;
  logic [31:0] lf;
  // comparator: input sits half a step above its code
  wire         cmp   = ({vin, 1'b1} > {dac, 1'b0});
  // released line shows a changing pattern
  wire         readout_serial_out = oe_n ? flip : sdo;

  acsr_top acsr_top_inst (
    .i_clock(clk), .i_rst_b(rst_b), .i_convert_start_n(cs_n), .o_busy(busy),
    .o_track_hold(th), .o_power_down(pd), .i_comparator_above(cmp), .o_dac_code(dac),
    .i_serial_clock(sclk), .o_readout_serial_out(sdo), .o_readout_serial_oe_n(oe_n)
  );
  acsr_host acsr_host_inst (
    .i_go(go), .i_readout_serial_out(readout_serial_out), .o_sclk(sclk), .o_word(word), .o_done(done)
  );

  // clock generator
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) flip <= ~flip;

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  // one conversion; keep_low holds the start pin low to its end
  task automatic convert(input acsr_code_t v, input logic keep_low, input int lim);
    int n;
    n = 0;
    vin = v;
    cs_n = 1'b0;
    cyc(5);
    `CHK("busy_high", 1'b1, busy)
    `CHK("track_hold", 1'b1, th)
    cs_n = ~keep_low;
    while (busy === 1'b1 && n < 1600) begin
      cyc(1);
      n++;
    end
    `CHK("conv_time", 1'b1, n + 5 <= lim)
    `CHK("track_again", 1'b0, th)
    cyc(1);
    `CHK("power_down", keep_low, pd)
    expq.push_back({4'h0, v});
  endtask : convert

  // read between conversions, and once while a conversion is stalled on a full buffer
  task automatic read_frame;
    go = 1'b1;
    cyc(1);
    go = 1'b0;
    @(posedge done);
    #15;
    `CHK("hold_last", 1'b0, oe_n)
    // line is free for one cycle before a waiting result reloads it
    #29;
    `CHK("released", 1'b1, oe_n)
    // quiet gap before any following start
    cyc(41);
  endtask : read_frame

  // closing task
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // frame checker takes the oldest expected code
  always @(posedge done) begin
    `CHK("lead_zeros", 4'h0, word[15:12])
    `CHK("frame_code", expq[0][11:0], word[11:0])
    void'(expq.pop_front());
  end

  // watchdog
  initial begin
    #400000;
    fails++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    rst_b = 1'b0;
    cs_n = 1'b1;
    go = 1'b0;
    flip = 1'b0;
    vin = '0;
    fails = 0;
    tests_run = 0;
    lf = 32'h6587;
    cyc(12);
    rst_b = 1'b1;
    cyc(4);
    `CHK("idle_line", 1'b1, oe_n)
    // boundary codes
    convert(12'h000, 1'b0, 800);
    read_frame();
    convert(12'hfff, 1'b0, 800);
    read_frame();
    // power-down, then start during wake-up
    convert(12'ha5c, 1'b1, 800);
    cs_n = 1'b1;
    cyc(6);
    `CHK("woken", 1'b0, pd)
    convert(12'h35a, 1'b0, 1394);
    read_frame();
    read_frame();
    // fill frame and buffer with random codes, unread
    for (int i = 0; i < 9; i++) begin
      lf = lfsr(lf);
      convert(lf[11:0], 1'b0, 800);
    end
    // tenth result finds the buffer full and stalls
    lf = lfsr(lf);
    vin = lf[11:0];
    cs_n = 1'b0;
    cyc(5);
    cs_n = 1'b1;
    cyc(900);
    `CHK("stalled", 1'b1, busy)
    read_frame();
    cyc(20);
    `CHK("unstalled", 1'b0, busy)
    expq.push_back({4'h0, vin});
    for (int i = 0; i < 9; i++) begin
      read_frame();
    end
    `CHK("all_read", 0, expq.size())
    tally_and_finish();
  end
endmodule : acsr_top_tb
